// [hw/acsc_pkg.sv]
// Purpose: Shared constants and types for the converter channel/setup block
// Assumes: 250 MHz core clock; register port fed by the serial-bus front end
// Notes:   Register offsets are the device's register pointer values
package acsc_pkg;

  // Core clock period and timing figures
  localparam int CLK_PERIOD_PS     = 4000;
  localparam int FILTER_TIME_NS    = 50;
  localparam int FILTER_CYCLES     =
    (FILTER_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int AUTO_BASE_TIME_US = 100;
  localparam int AUTO_BASE_CYCLES  =
    (AUTO_BASE_TIME_US * 1000000) / CLK_PERIOD_PS;
  localparam int FILT_CNT_W        = 4;
  localparam int AUTO_CNT_W        = 18;

  // Register pointer values
  localparam logic [7:0] ADDR_CHAN = 8'h01;
  localparam logic [7:0] ADDR_CFG  = 8'h02;

  // Reset values and writable-bit masks
  localparam logic [7:0]  CHAN_RESET   = 8'h00;
  localparam logic [7:0]  CHAN_WR_MASK = 8'h0f;
  localparam logic [15:0] CFG_RESET    = 16'h00c0;
  localparam logic [15:0] CFG_WR_MASK  = 16'hcfff;

  // Configuration field positions
  localparam int CFG_DRIVE_BIT  = 15;
  localparam int CFG_SPARE2_BIT = 14;
  localparam int CFG_BYPASS_BIT = 11;
  localparam int CFG_CMD_BIT    = 10;
  localparam int CFG_SRESET_BIT = 9;
  localparam int CFG_AUTO_BIT   = 8;
  localparam int CFG_CYC_HI     = 7;
  localparam int CFG_CYC_LO     = 6;
  localparam int CFG_BUSY_BIT   = 5;
  localparam int CFG_FUNC_BIT   = 4;
  localparam int CFG_POL_BIT    = 3;
  localparam int CFG_SPARE1_BIT = 2;
  localparam int CFG_PD_HI      = 1;
  localparam int CFG_PD_LO      = 0;

  // Conversion modes, Gray coded
  typedef enum logic [1:0] {
    ACSC_MODE_SAMPLE = 2'b00,
    ACSC_MODE_AUTO   = 2'b01,
    ACSC_MODE_CMD    = 2'b11
  } acsc_mode_e;

  // Register access request from the serial-bus front end
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } acsc_reg_req_s;

endpackage

// [hw/acsc_line_filter.sv]
// Purpose: Glitch filter for the two serial-bus lines
// Assumes: Line inputs already synchronous to clock
// Notes:   A line level passes only after holding FILTER_CYCLES cycles
`timescale 1ns/1ps
`default_nettype none
module acsc_line_filter
  import acsc_pkg::*;
(
  input  wire logic       clock,    // Core clock
  input  wire logic       rst_b,    // Async reset, active low
  input  wire logic       bypass,   // 1 passes lines unfiltered
  input  wire logic [1:0] line_in,  // Raw lines {scl, sda}
  output logic      [1:0] line_out  // Filtered lines
);

  localparam logic [FILT_CNT_W-1:0] HOLD_MAX =
    FILT_CNT_W'(FILTER_CYCLES - 1);

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_line
      logic                  level_reg;
      logic                  level_next;
      logic [FILT_CNT_W-1:0] cnt_reg;
      logic [FILT_CNT_W-1:0] cnt_next;

      // Count cycles the raw level differs from the passed level
      always_comb begin
        level_next = level_reg;
        cnt_next   = '0;
        if (bypass) begin
          level_next = line_in[gi]; // RULE9
        end else if (line_in[gi] != level_reg) begin
          if (cnt_reg == HOLD_MAX) begin
            level_next = line_in[gi]; // RULE9
          end else begin
            cnt_next = cnt_reg + 1'b1;
          end
        end
      end

      // Idle bus lines sit high
      always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
          level_reg <= 1'b1;
          cnt_reg   <= '0;
        end else begin
          level_reg <= level_next;
          cnt_reg   <= cnt_next;
        end
      end

      assign line_out[gi] = level_reg;
    end
  endgenerate

endmodule
`default_nettype wire

// [hw/acsc_top.sv]
// Purpose: Input-selection and setup registers of a four-input converter
// Assumes: Register port driven by the serial-bus front end, one-cycle
//          strobes; conversion done and busy come from the converter core
// Notes:   Result and alert registers live outside; soft_reset clears them
//          Setup bit 3 doubles as polarity and general output value
`timescale 1ns/1ps
`default_nettype none
// How it works
// (RULE1) Input selection register is 8 bits, host readable and writable.
// (RULE2) Only inputs whose selection bit is 1 enter the sequence.
// (RULE3) New selection reaches the sequence after one more conversion.
// (RULE4) Selection write restarts sequence at lowest enabled new input.
// (RULE5) Bits 3..0 select inputs, reset 0; bits 7..4 read zero.
// (RULE6) Setup register is 16 bits, readable and writable, sets modes.
// (RULE7) Setup bit 15: status pin open-drain at 0, push-pull at 1.
// (RULE8) Setup bit 14 sets level on spare output two.
// (RULE9) Setup bit 11 at 0 filters bus lines 50 ns; 1 bypasses.
// (RULE10) Bits 10 and 8 choose sample, autocycle or command mode.
// (RULE11) Bit 9 soft-resets logic, result and alert; self-clears next cycle.
// (RULE12) Bit 5 at 1 puts converter busy on the status pin.
// (RULE13) Bits 7..6 pick autocycle interval 100/200/400/800 us, reset 11.
// (RULE14) Bit 4 at 1 makes status pin a general output.
// (RULE15) Reserved bits ignore writes and read back zero.
module acsc_top
  import acsc_pkg::*;
#(
  parameter int AUTO_BASE_CNT = AUTO_BASE_CYCLES // 100 us in clock cycles
)(
  input  wire logic          clock,             // Core clock 250 MHz
  input  wire logic          rst_b,             // Power-on reset, low
  input  wire acsc_reg_req_s reg_req,           // Register access strobes
  output logic [15:0]        reg_rdata,         // Read data, held
  input  wire logic          conv_done,         // Conversion finished pulse
  input  wire logic          conv_busy,         // Conversion in progress
  input  wire logic          alert_active,      // Alert condition level
  input  wire logic          scl_in,            // Raw bus clock line
  input  wire logic          sda_in,            // Raw bus data line
  output logic               scl_filt,          // Filtered bus clock
  output logic               sda_filt,          // Filtered bus data
  output logic [1:0]         conv_channel,      // Input to convert next
  output logic               sequence_valid,    // Some input enabled
  output acsc_mode_e         conv_mode,         // Decoded conversion mode
  output logic               auto_convert,      // Autocycle start pulse
  output logic               soft_reset,        // Soft reset pulse
  output logic               status_output_pin, // Status pin drive level
  output logic               status_pin_oe,     // Status pin enable
  output logic               spare_output_two_level, // Spare output two
  output logic               spare_output_one_level, // Spare output one
  output logic [1:0]         power_down_mode    // Power-down setting
);

  // Register state
  // Read data is a flop so reg_rdata comes straight from a register
  logic [7:0]  chan_reg;
  logic [7:0]  chan_next;
  logic [15:0] cfg_reg;
  logic [15:0] cfg_next;
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;

  // Sequencer state
  logic [3:0]  active_reg;
  logic [3:0]  active_next;
  logic        pend_reg;
  logic        pend_next;
  logic [1:0]  cur_reg;
  logic [1:0]  cur_next;
  logic        valid_reg;
  logic        valid_next;

  // Autocycle timer and pin state
  logic [AUTO_CNT_W-1:0] acnt_reg;
  logic [AUTO_CNT_W-1:0] acnt_next;
  logic [AUTO_CNT_W-1:0] acnt_limit;
  logic        astart_reg;
  logic        astart_next;
  acsc_mode_e  mode_reg;
  acsc_mode_e  mode_next;
  logic        pin_reg;
  logic        pin_next;
  logic        oe_reg;
  logic        oe_next;
  logic        pin_level;

  // Named selection and setup fields
  logic [3:0]  input_convert_enable;
  logic        bus_glitch_filter_bypass;
  logic        soft_reset_trigger;
  logic        status_pin_function_select;

  assign input_convert_enable       = chan_reg[3:0];
  assign bus_glitch_filter_bypass   = cfg_reg[CFG_BYPASS_BIT];
  // Soft reset is the stored bit itself, so each setup write that sets it gives one cycle
  assign soft_reset_trigger         = cfg_reg[CFG_SRESET_BIT];
  assign status_pin_function_select = cfg_reg[CFG_FUNC_BIT];

  // Lowest enabled input in a mask
  // An empty mask gives input 0; sequence_valid tells the core to idle
  function automatic logic [1:0] lowest_en(input logic [3:0] m);
    logic [1:0] r;
    r = 2'd0;
    for (int i = 3; i >= 0; i--) begin
      if (m[i]) r = 2'(i);
    end
    return r;
  endfunction

  // Next enabled input above cur, wrapping to lowest
  // Used only with the mask in use, never with a pending selection
  function automatic logic [1:0] next_en(input logic [3:0] m,
                                         input logic [1:0] cur);
    logic [1:0] r;
    logic       hit;
    r   = lowest_en(m);
    hit = 1'b0;
    for (int i = 0; i < 4; i++) begin
      if (!hit && m[i] && (2'(i) > cur)) begin
        r   = 2'(i);
        hit = 1'b1;
      end
    end
    return r;
  endfunction

  // Register writes and reads
  // Reads return the value before a write in the same cycle; the soft
  // reset bit drops on its own one cycle after it is written, unless a
  // new write sets it again. Reserved bits never reach the flops.
  always_comb begin
    chan_next  = chan_reg;
    cfg_next   = cfg_reg;
    rdata_next = rdata_reg;
    cfg_next[CFG_SRESET_BIT] = 1'b0; // RULE11
    if (reg_req.wr && reg_req.addr == ADDR_CHAN) begin
      chan_next = reg_req.wdata[7:0] & CHAN_WR_MASK; // RULE1 RULE5 RULE15
    end
    if (reg_req.wr && reg_req.addr == ADDR_CFG) begin
      cfg_next = reg_req.wdata & CFG_WR_MASK; // RULE6 RULE15
    end
    if (reg_req.rd) begin
      case (reg_req.addr)
        ADDR_CHAN: rdata_next = {8'h00, chan_reg & CHAN_WR_MASK}; // RULE1
        ADDR_CFG:  rdata_next = cfg_reg & CFG_WR_MASK;            // RULE6
        default:   rdata_next = 16'h0000;
      endcase
    end
  end

  // Power-on reset only; soft reset leaves these intact
  // Setup bits 7..6 come out of reset as 11, the longest interval
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      chan_reg  <= CHAN_RESET;
      cfg_reg   <= CFG_RESET; // RULE13
      rdata_reg <= 16'h0000;
    end else begin
      chan_reg  <= chan_next;
      cfg_reg   <= cfg_next;
      rdata_reg <= rdata_next;
    end
  end

  // Input sequencer
  // A selection write only raises the pending flag; the mask in use
  // changes at the next finished conversion, which keeps the input the
  // core is converting now consistent with the channel it reported
  always_comb begin
    active_next = active_reg;
    pend_next   = pend_reg;
    cur_next    = cur_reg;
    if (reg_req.wr && reg_req.addr == ADDR_CHAN) begin
      pend_next = 1'b1; // RULE3
    end
    if (conv_done) begin
      if (pend_reg) begin
        active_next = input_convert_enable;      // RULE3
        cur_next    = lowest_en(input_convert_enable); // RULE4
        pend_next   = reg_req.wr && reg_req.addr == ADDR_CHAN;
      end else begin
        cur_next = next_en(active_reg, cur_reg); // RULE2
      end
    end
    // Soft reset applies the stored selection at once; a selection
    // written in the same cycle stays pending, so that write is not lost
    if (soft_reset_trigger) begin
      active_next = input_convert_enable; // RULE11
      cur_next    = lowest_en(input_convert_enable);
      pend_next   = reg_req.wr && reg_req.addr == ADDR_CHAN; // RULE3
    end
    valid_next = |active_next; // RULE2
  end

  // Sequencer flops, cleared by power-on reset only
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      active_reg <= 4'h0;
      pend_reg   <= 1'b0;
      cur_reg    <= 2'd0;
      valid_reg  <= 1'b0;
    end else begin
      active_reg <= active_next;
      pend_reg   <= pend_next;
      cur_reg    <= cur_next;
      valid_reg  <= valid_next;
    end
  end

  // Mode decode and autocycle interval timer
  // The counter runs 0 .. limit-1 and the start pulse rises in the cycle
  // after the last count, so pulses are exactly limit cycles apart; the
  // counter is held at zero outside autocycle and during soft reset
  always_comb begin
    case ({cfg_reg[CFG_CMD_BIT], cfg_reg[CFG_AUTO_BIT]})
      2'b01:   mode_next = ACSC_MODE_AUTO;   // RULE10
      2'b10:   mode_next = ACSC_MODE_CMD;    // RULE10
      default: mode_next = ACSC_MODE_SAMPLE; // RULE10
    endcase
    acnt_limit = AUTO_CNT_W'(AUTO_BASE_CNT)
                 << cfg_reg[CFG_CYC_HI:CFG_CYC_LO]; // RULE13
    acnt_next   = '0;
    astart_next = 1'b0;
    if (mode_reg == ACSC_MODE_AUTO && !soft_reset_trigger) begin
      if (acnt_reg >= acnt_limit - 1'b1) begin
        astart_next = 1'b1; // RULE13
      end else begin
        acnt_next = acnt_reg + 1'b1;
      end
    end
  end

  // Mode, counter and pulse flops
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      mode_reg   <= ACSC_MODE_SAMPLE;
      acnt_reg   <= '0;
      astart_reg <= 1'b0;
    end else begin
      mode_reg   <= mode_next;
      acnt_reg   <= acnt_next;
      astart_reg <= astart_next;
    end
  end

  // Status pin function, polarity and drive type
  // Polarity bit 0 means active low. In open-drain mode the pin value is
  // always 0 and only the enable moves: enable high pulls the line low,
  // enable low lets the external pull-up show a high level
  always_comb begin
    if (status_pin_function_select) begin
      pin_level = cfg_reg[CFG_POL_BIT]; // RULE14
    end else if (cfg_reg[CFG_BUSY_BIT]) begin
      pin_level = conv_busy ~^ cfg_reg[CFG_POL_BIT]; // RULE12
    end else begin
      pin_level = alert_active ~^ cfg_reg[CFG_POL_BIT]; // RULE14
    end
    if (cfg_reg[CFG_DRIVE_BIT]) begin
      pin_next = pin_level; // RULE7
      oe_next  = 1'b1;
    end else begin
      pin_next = 1'b0; // RULE7
      oe_next  = !pin_level;
    end
  end

  // Pin flops; reset leaves the pin released
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pin_reg <= 1'b0;
      oe_reg  <= 1'b0;
    end else begin
      pin_reg <= pin_next;
      oe_reg  <= oe_next;
    end
  end

  // Bus line glitch filter
  // Filtered lines leave reset high, the idle bus level, so the front
  // end sees no false start condition as reset is released
  acsc_line_filter u_filter (
    .clock    (clock),
    .rst_b    (rst_b),
    .bypass   (bus_glitch_filter_bypass),
    .line_in  ({scl_in, sda_in}),
    .line_out ({scl_filt, sda_filt})
  );

  // Outputs straight from flops
  // Field outputs are register bits themselves, so no extra delay
  assign reg_rdata              = rdata_reg;
  assign conv_channel           = cur_reg;
  assign sequence_valid         = valid_reg;
  assign conv_mode              = mode_reg;
  assign auto_convert           = astart_reg;
  assign soft_reset             = soft_reset_trigger; // RULE11
  assign status_output_pin      = pin_reg;
  assign status_pin_oe          = oe_reg;
  assign spare_output_two_level = cfg_reg[CFG_SPARE2_BIT]; // RULE8
  assign spare_output_one_level = cfg_reg[CFG_SPARE1_BIT];
  assign power_down_mode        = cfg_reg[CFG_PD_HI:CFG_PD_LO];

endmodule
`default_nettype wire

// [verification/acsc_top_chk.sv]
// Purpose: Port-level assertions for acsc_top
// Assumes: One clock domain, async active-low reset
// Notes:   Attached by the bind at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module acsc_top_chk
  import acsc_pkg::*;
#(
  parameter int AUTO_BASE_CNT = AUTO_BASE_CYCLES // Autocycle base count
)(
  input wire logic          clock,        // Core clock
  input wire logic          rst_b,        // Reset, active low
  input wire acsc_reg_req_s reg_req,      // Register strobes
  input wire logic [15:0]   reg_rdata,    // Read data
  input wire logic          conv_done,    // Conversion finished
  input wire logic [1:0]    conv_channel, // Channel in use
  input wire logic          soft_reset,   // Soft reset pulse
  input wire logic          auto_convert, // Autocycle pulse
  input wire logic          status_output_pin, // Status pin level
  input wire logic          status_pin_oe,     // Status pin enable
  input wire logic          spare_output_two_level // Spare two
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  logic cfg_wr;
  // Setup write strobe
  assign cfg_wr = reg_req.wr && reg_req.addr == ADDR_CFG;
  sequence soft_reset_trigger_s;
    ##1 soft_reset ##1 !soft_reset;
  endsequence
  soft_reset_trigger_pulse_a: assert property (cfg_wr && reg_req.wdata[9] |->
    soft_reset_trigger_s)
    else $error("soft reset pulse wrong");
  spare_two_a: assert property (cfg_wr |=>
    spare_output_two_level == $past(reg_req.wdata[14]))
    else $error("spare output two wrong");
  open_drain_a: assert property (!status_pin_oe |->
    !status_output_pin)
    else $error("status pin driven high while released");
  chan_hold_a: assert property (!conv_done && !soft_reset &&
    !(cfg_wr && reg_req.wdata[9]) |=> $stable(conv_channel))
    else $error("channel moved without conversion");
  unmapped_read_a: assert property (reg_req.rd && reg_req.addr !=
    ADDR_CHAN && reg_req.addr != ADDR_CFG |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  chan_rsvd_a: assert property (reg_req.rd &&
    reg_req.addr == ADDR_CHAN |=> reg_rdata[15:4] == 12'h000)
    else $error("selection reserved bits set");
  cfg_rsvd_a: assert property (reg_req.rd && reg_req.addr == ADDR_CFG
    |=> reg_rdata[13:12] == 2'h0)
    else $error("setup reserved bits set");
  auto_pulse_a: assert property (auto_convert |=> !auto_convert [*8])
    else $error("autocycle pulses too close");
endmodule
bind acsc_top acsc_top_chk #(.AUTO_BASE_CNT(AUTO_BASE_CNT)) u_chk (
  .clock(clock), .rst_b(rst_b), .reg_req(reg_req), .reg_rdata(reg_rdata),
  .conv_done(conv_done), .conv_channel(conv_channel),
  .soft_reset(soft_reset), .auto_convert(auto_convert),
  .status_output_pin(status_output_pin), .status_pin_oe(status_pin_oe),
  .spare_output_two_level(spare_output_two_level));
`default_nettype wire

// [verification/acsc_host_bfm.sv]
// Purpose: Host side of the register port
// Assumes: Requests launched after a falling edge
// Notes:   Released address and data show the inverse of the last value; strobes go to 0
`timescale 1ns/1ps
`default_nettype none
module acsc_host_bfm
  import acsc_pkg::*;
(
  input  wire logic         clock,     // Core clock
  input  wire logic [15:0]  reg_rdata, // Read data
  output var acsc_reg_req_s req        // Register strobes
);
  initial req = '0;
  // One access held across one rising edge, answer taken after it
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [15:0] d, output logic [15:0] q);
    @(negedge clock);
    req = '{w, !w, a, d};
    @(negedge clock);
    q = reg_rdata;
    req = '{1'b0, 1'b0, ~a, ~d};
  endtask
endmodule
`default_nettype wire

// [verification/adc_channel_sequence_config_test.sv]
// Purpose: Self-checking bench for acsc_top
// Assumes: Inputs driven at falling edge, short autocycle base
// Notes:   Integer model of registers and sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin cmp_count++; if ((gt) !== (ex)) begin \
  n_errors++; $display("[FAIL] %s exp %0h got %0h", nm, ex, gt); end end
module adc_channel_sequence_config_test
  import acsc_pkg::*;
;
  localparam int BASE = 20;
  logic          clock = 1'b0;
  logic          rst_b = 1'b0;
  acsc_reg_req_s reg_req;
  logic [15:0]   reg_rdata, q;
  logic          conv_done = 1'b0, conv_busy = 1'b0, alert_active = 1'b0;
  logic [1:0]    lines = 2'b11, conv_channel, pd;
  logic          scl_filt, sda_filt, seq_ok, auto_convert;
  logic          soft_reset, pin, pin_oe, sp2, sp1;
  acsc_mode_e    conv_mode;
  int n_errors = 0, cmp_count = 0, sel = 0, cfg = 32'hc0, act = 0, ch = 0;
  int pend = 0, t;
  int tc[8] = '{32'h8028b, 32'h80285, 32'h00288, 32'h00281, 32'h80183,
                32'h8010d, 32'h80087, 32'h80005};
  // 250 MHz clock
  always #2 clock = ~clock;
  acsc_host_bfm host (.clock(clock), .reg_rdata(reg_rdata), .req(reg_req));
  acsc_top #(.AUTO_BASE_CNT(BASE)) DUT (.clock(clock), .rst_b(rst_b),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .conv_done(conv_done),
    .conv_busy(conv_busy), .alert_active(alert_active),
    .scl_in(lines[1]), .sda_in(lines[0]), .scl_filt(scl_filt),
    .sda_filt(sda_filt), .conv_channel(conv_channel),
    .sequence_valid(seq_ok), .conv_mode(conv_mode),
    .auto_convert(auto_convert), .soft_reset(soft_reset),
    .status_output_pin(pin), .status_pin_oe(pin_oe),
    .spare_output_two_level(sp2), .spare_output_one_level(sp1),
    .power_down_mode(pd));
  function automatic int low(int m);
    for (int i = 0; i < 4; i++) if (m[i]) return i;
    return 0;
  endfunction
  function automatic int nxt(int m, int c);
    for (int i = c + 1; i < 4; i++) if (m[i]) return i;
    return low(m);
  endfunction
  task automatic wr(input int a, input int d);
    host.xfer(1'b1, a[7:0], d[15:0], q);
    if (a == 1) begin
      sel = d & 32'hf;
      pend = 1;
    end
    if (a == 2) cfg = d & CFG_WR_MASK & 32'hfdff;
  endtask
  task automatic rd(input int a);
    host.xfer(1'b0, a[7:0], 16'h0000, q);
    `CHK("rdata", a == 1 ? sel : a == 2 ? cfg : 0, q)
  endtask
  task automatic done();
    @(negedge clock) conv_done = 1'b1;
    @(negedge clock) conv_done = 1'b0;
    if (pend) begin
      act = sel;
      ch = low(act);
      pend = 0;
    end else ch = nxt(act, ch);
    `CHK("chan", ch, conv_channel)
    `CHK("valid", act != 0, seq_ok)
  endtask
  task automatic gap(output int n);
    n = 1;
    for (int k = 0; k < 400 && !auto_convert; k++) @(negedge clock);
    @(negedge clock);
    while (!auto_convert && n < 400) begin
      @(negedge clock);
      n++;
    end
  endtask
  task automatic wrap_up();
    if (n_errors == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Watchdog far beyond the roughly 1000 cycles the tests need
  initial begin
    #(4 * 20000);
    n_errors++;
    wrap_up();
  end
  // Main sequence
  initial begin
    void'($urandom(32'h2d9f));
    repeat (4) @(posedge clock);
    @(negedge clock) rst_b = 1'b1;
    rd(1);
    rd(2);
    for (int i = 0; i < 8; i++) begin
      t = $urandom & 32'hfffffdff;
      t[10] = i[1];
      t[8] = i[0];
      wr(2, t);
      rd(2);
      `CHK("mode", i % 4 == 1 ? 1 : i % 4 == 2 ? 3 : 0, conv_mode)
      `CHK("spare2", t[14], sp2)
      `CHK("outs", t[2:0], {sp1, pd})
      wr(1, $urandom);
      rd(1);
      wr(i + 3, $urandom);
      rd(i + 3);
    end
    wr(1, 32'ha);
    `CHK("hold", ch, conv_channel)
    repeat (3) done();
    wr(1, 32'h9);
    `CHK("hold", ch, conv_channel)
    repeat (3) done();
    wr(1, 32'h6);
    wr(2, 32'h0200);
    `CHK("soft_reset_trigger", 1, soft_reset)
    act = sel;
    ch = low(sel);
    pend = 0;
    @(negedge clock);
    `CHK("soft_reset_trigger", 0, soft_reset)
    `CHK("chan", ch, conv_channel)
    rd(2);
    rd(1);
    foreach (tc[k]) begin
      wr(2, tc[k] >> 4);
      {conv_busy, alert_active} = tc[k][3:2];
      repeat (2) @(negedge clock);
      `CHK("pin", tc[k][1:0], {pin, pin_oe})
    end
    wr(2, 32'h0800);
    lines = 2'b01;
    repeat (20) @(negedge clock);
    `CHK("bypass", 1, {scl_filt, sda_filt})
    wr(2, 0);
    lines = 2'b10;
    repeat (10) @(negedge clock);
    `CHK("glitch", 1, {scl_filt, sda_filt})
    repeat (10) @(negedge clock);
    `CHK("filter", 2, {scl_filt, sda_filt})
    for (int c = 0; c < 4; c++) begin
      wr(2, 32'h0100 | c << 6);
      gap(t);
      `CHK("period", BASE << c, t)
    end
    wrap_up();
  end
endmodule
`default_nettype wire
